// [rtl/pwu_top.v]
`timescale 1ns/1ps
`default_nettype none
`include "pwu_defines.vh"

// ============================================================
// Multi-pin wakeup and port interrupt logic with APB access
module pwu_top #(
    parameter PINS = 8,
    parameter ADDR_W = 8,
    parameter TC_DIV = `PWU_TC_DIV,
    parameter STARTUP = `PWU_STARTUP_COUNT
) (
    input wire clock,
    input wire rst_b,
    input wire [ADDR_W-1:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output reg pslverr,
    input wire [PINS-1:0] port_in,
    output wire port_irq_req,
    output wire irq,
    output reg core_clk_en,
    output reg osc_en,
    output reg wake_pulse,
    output reg wake_to_isr
);

    // ========================================================
    // Power states
    localparam ST_RUN = 2'b00;
    localparam ST_IDLE = 2'b01;
    localparam ST_HALT = 2'b10;
    localparam ST_START = 2'b11;

    // ========================================================
    // Register state
    reg [PINS-1:0] wake_enable_mask_q; // Per-pin enable
    reg [PINS-1:0] wake_edge_select_q; // 1 = falling edge
    reg [PINS-1:0] wake_pending_q; // Latched edges
    reg [PINS-1:0] wake_pending_d;
    reg port_irq_enable_q; // Port-level gate
    reg global_irq_enable_q; // Core-wide gate
    reg [`PWU_EVT_W-1:0] evt_status_q; // Sticky events
    reg [`PWU_EVT_W-1:0] evt_status_d;
    reg [`PWU_EVT_W-1:0] evt_mask_q; // Event interrupt mask
    reg [1:0] state_q;
    reg [1:0] state_d;

    // ========================================================
    // Pin sampling
    reg [PINS-1:0] pin_meta_q; // First synchroniser stage, read only by next stage
    reg [PINS-1:0] pin_sync_q; // Second synchroniser stage
    reg [PINS-1:0] pin_prev_q; // Previous synchronised sample
    wire [PINS-1:0] rise_hit;
    wire [PINS-1:0] fall_hit;
    wire [PINS-1:0] edge_hit;

    // ========================================================
    // Bus decode
    wire setup_ph;
    wire wr_acc;
    wire rd_acc;
    reg addr_ok;
    reg [31:0] rd_mux;

    // ========================================================
    // Derived terms
    wire [PINS-1:0] en_pend;
    wire any_wake;
    wire halt_req;
    wire idle_req;
    wire tc_tick;
    wire timer_done;
    reg timer_load;
    reg [7:0] div_q; // Instruction-cycle divider
    reg ev_wake;
    reg ev_refused;

    // ========================================================
    // Helper functions
    // Zero-extend a pin-wide vector to the bus width
    function [31:0] widen;
        input [PINS-1:0] v;
        begin
            widen = {{(32-PINS){1'b0}}, v};
        end
    endfunction

    // Pending-bit next value: a detected edge beats a same-cycle write
    function [PINS-1:0] merge_set;
        input [PINS-1:0] cur;
        input [PINS-1:0] wval;
        input wen;
        input [PINS-1:0] setv;
        begin
            merge_set = (wen ? wval : cur) | setv;
        end
    endfunction

    // ========================================================
    // Synchroniser and edge detector
    // Three stages: two to settle the level, one to hold the last sample.
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            pin_meta_q <= {PINS{1'b0}};
            pin_sync_q <= {PINS{1'b0}};
            pin_prev_q <= {PINS{1'b0}};
        end else begin
            pin_meta_q <= port_in;
            pin_sync_q <= pin_meta_q;
            pin_prev_q <= pin_sync_q;
        end
    end

    // Edge selection per pin; only the settled samples are compared
    assign rise_hit = pin_sync_q & ~pin_prev_q;
    assign fall_hit = ~pin_sync_q & pin_prev_q;
    assign edge_hit = (wake_edge_select_q & fall_hit) | (~wake_edge_select_q & rise_hit);

    // ========================================================
    // APB access qualifiers
    // Zero wait states: the slave always answers in the access phase.
    assign pready = 1'b1;
    assign setup_ph = psel & ~penable;
    assign wr_acc = psel & penable & pwrite & addr_ok;
    assign rd_acc = psel & penable & ~pwrite & addr_ok;

    // ========================================================
    // Address decode and read multiplexer
    always @* begin
        addr_ok = 1'b1;
        rd_mux = 32'h0000_0000;
        if (paddr == `PWU_OFF_WAKE_EN) begin
            rd_mux = widen(wake_enable_mask_q);
        end else if (paddr == `PWU_OFF_WAKE_EDGE) begin
            rd_mux = widen(wake_edge_select_q);
        end else if (paddr == `PWU_OFF_WAKE_PEND) begin
            rd_mux = widen(wake_pending_q);
        end else if (paddr == `PWU_OFF_IRQ_CTRL) begin
            rd_mux[`PWU_CTRL_PORT_IRQ_EN] = port_irq_enable_q;
            rd_mux[`PWU_CTRL_GLOBAL_IRQ_EN] = global_irq_enable_q;
        end else if (paddr == `PWU_OFF_POWER) begin
            rd_mux = {30'h0000_0000, state_q};
        end else if (paddr == `PWU_OFF_EVT_STATUS) begin
            rd_mux = {29'h0000_0000, evt_status_q};
        end else if (paddr == `PWU_OFF_EVT_MASK) begin
            rd_mux = {29'h0000_0000, evt_mask_q};
        end else begin
            // Unmapped: reads zero and errors in the access phase
            addr_ok = 1'b0;
        end
    end

    // ========================================================
    // Read data and error flops
    // Captured in the setup phase so the access phase shows a stable word.
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup_ph) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr <= ~addr_ok;
        end else if (!psel) begin
            pslverr <= 1'b0;
        end
    end

    // ========================================================
    // Configuration registers
    // Cleared at reset; until software programs the edges, the floating
    // pins can latch pending bits, but none wakes while enables are zero.
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wake_enable_mask_q <= `PWU_RST_BYTE;
            wake_edge_select_q <= `PWU_RST_BYTE;
            port_irq_enable_q <= 1'b0;
            global_irq_enable_q <= 1'b0;
            evt_mask_q <= `PWU_RST_EVT;
        end else if (wr_acc) begin
            if (paddr == `PWU_OFF_WAKE_EN) begin
                wake_enable_mask_q <= pwdata[PINS-1:0];
            end else if (paddr == `PWU_OFF_WAKE_EDGE) begin
                wake_edge_select_q <= pwdata[PINS-1:0];
            end else if (paddr == `PWU_OFF_IRQ_CTRL) begin
                port_irq_enable_q <= pwdata[`PWU_CTRL_PORT_IRQ_EN];
                global_irq_enable_q <= pwdata[`PWU_CTRL_GLOBAL_IRQ_EN];
            end else if (paddr == `PWU_OFF_EVT_MASK) begin
                evt_mask_q <= pwdata[`PWU_EVT_W-1:0];
            end
        end
    end

    // ========================================================
    // Pending register
    // Software is the only clearer; hardware only ever sets bits.
    always @* begin
        wake_pending_d = merge_set(wake_pending_q, pwdata[PINS-1:0],
            wr_acc & (paddr == `PWU_OFF_WAKE_PEND), edge_hit);
    end

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wake_pending_q <= `PWU_RST_BYTE;
        end else begin
            wake_pending_q <= wake_pending_d;
        end
    end

    // ========================================================
    // Port interrupt request
    // Built from registered enables, so a write clearing an enable still
    // lets the request of that same cycle through to the core.
    assign en_pend = wake_enable_mask_q & wake_pending_q;
    assign any_wake = |en_pend;
    assign port_irq_req = any_wake & port_irq_enable_q & global_irq_enable_q;

    // ========================================================
    // Power-mode requests from the power register
    assign halt_req = wr_acc & (paddr == `PWU_OFF_POWER) & pwdata[`PWU_PWR_HALT];
    assign idle_req = wr_acc & (paddr == `PWU_OFF_POWER) & pwdata[`PWU_PWR_IDLE]
        & ~pwdata[`PWU_PWR_HALT];

    // ========================================================
    // Instruction-cycle tick divider
    // Runs only while the oscillator runs, so the start-up count
    // measures real oscillator cycles.
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            div_q <= 8'h00;
        end else if (!osc_en || (div_q == TC_DIV[7:0] - 8'h01)) begin
            div_q <= 8'h00;
        end else begin
            div_q <= div_q + 8'h01;
        end
    end

    assign tc_tick = osc_en & (div_q == TC_DIV[7:0] - 8'h01);

    // ========================================================
    // Start-up delay timer
    pwu_idle_timer #(
        .LOAD(STARTUP),
        .CNT_W(9)
    ) u_timer (
        .clock(clock),
        .rst_b(rst_b),
        .load(timer_load),
        .tick(tc_tick),
        .busy(),
        .expired(timer_done)
    );

    // ========================================================
    // Power-mode state machine
    always @* begin
        state_d = state_q;
        timer_load = 1'b0;
        ev_wake = 1'b0;
        ev_refused = 1'b0;
        case (state_q)
            ST_RUN: begin
                if (halt_req) begin
                    if (any_wake) begin
                        ev_refused = 1'b1;
                    end else begin
                        state_d = ST_HALT;
                    end
                end else if (idle_req) begin
                    state_d = ST_IDLE;
                end
            end
            ST_IDLE: begin
                // Oscillator still runs, so resume at once
                if (any_wake) begin
                    state_d = ST_RUN;
                    ev_wake = 1'b1;
                end
            end
            ST_HALT: begin
                if (any_wake) begin
                    state_d = ST_START;
                    timer_load = 1'b1;
                end
            end
            default: begin
                // Core clock stays gated until the delay has run out; the oscillator runs
                if (timer_done) begin
                    state_d = ST_RUN;
                    ev_wake = 1'b1;
                end
            end
        endcase
    end

    // State register and clock-gate outputs
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= ST_RUN;
            core_clk_en <= 1'b1;
            osc_en <= 1'b1;
        end else begin
            state_q <= state_d;
            core_clk_en <= (state_d == ST_RUN);
            osc_en <= (state_d != ST_HALT);
        end
    end

    // ========================================================
    // Wake report to the core
    // With the port interrupt allowed the core vectors first;
    // otherwise it carries on after the power-save instruction.
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wake_pulse <= 1'b0;
            wake_to_isr <= 1'b0;
        end else begin
            wake_pulse <= ev_wake;
            if (ev_wake) begin
                wake_to_isr <= port_irq_enable_q & global_irq_enable_q;
            end
        end
    end

    // ========================================================
    // Sticky event status, cleared by reading it
    // A new event in the clearing cycle survives the read.
    always @* begin
        evt_status_d = evt_status_q;
        if (rd_acc && (paddr == `PWU_OFF_EVT_STATUS)) begin
            evt_status_d = `PWU_RST_EVT;
        end
        evt_status_d[`PWU_EVT_WAKE] = evt_status_d[`PWU_EVT_WAKE] | ev_wake;
        evt_status_d[`PWU_EVT_HALT_REFUSED] = evt_status_d[`PWU_EVT_HALT_REFUSED] | ev_refused;
        evt_status_d[`PWU_EVT_STARTUP_DONE] = evt_status_d[`PWU_EVT_STARTUP_DONE] | timer_done;
    end

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            evt_status_q <= `PWU_RST_EVT;
        end else begin
            evt_status_q <= evt_status_d;
        end
    end

    // Level interrupt while any unmasked event is held
    assign irq = |(evt_status_q & evt_mask_q);

endmodule
`default_nettype wire

// [rtl/pwu_defines.vh]
`ifndef PWU_DEFINES_VH
`define PWU_DEFINES_VH

// ============================================================
// Register offsets (byte addresses, one word each)
`define PWU_OFF_WAKE_EN 8'h00
`define PWU_OFF_WAKE_EDGE 8'h04
`define PWU_OFF_WAKE_PEND 8'h08
`define PWU_OFF_IRQ_CTRL 8'h0c
`define PWU_OFF_POWER 8'h10
`define PWU_OFF_EVT_STATUS 8'h14
`define PWU_OFF_EVT_MASK 8'h18

// ============================================================
// Field positions
`define PWU_CTRL_PORT_IRQ_EN 0
`define PWU_CTRL_GLOBAL_IRQ_EN 1
`define PWU_PWR_HALT 0
`define PWU_PWR_IDLE 1
`define PWU_EVT_WAKE 0
`define PWU_EVT_HALT_REFUSED 1
`define PWU_EVT_STARTUP_DONE 2
`define PWU_EVT_W 3

// ============================================================
// Reset values
`define PWU_RST_BYTE 8'h00
`define PWU_RST_EVT 3'h0

// ============================================================
// Timing counts
`define PWU_STARTUP_COUNT 256
`define PWU_TC_DIV 10

`endif

// [rtl/pwu_idle_timer.v]
`timescale 1ns/1ps
`default_nettype none
`include "pwu_defines.vh"

// ============================================================
// Start-up delay timer, clocked by the instruction-cycle tick
module pwu_idle_timer #(
    parameter LOAD = `PWU_STARTUP_COUNT,
    parameter CNT_W = 9
) (
    input wire clock,
    input wire rst_b,
    input wire load,
    input wire tick,
    output wire busy,
    output wire expired
);
    reg [CNT_W-1:0] cnt_q; // Remaining instruction cycles
    reg [CNT_W-1:0] cnt_d;

    // Load wins over a tick so a fresh wake always restarts the delay
    always @* begin
        cnt_d = cnt_q;
        if (load) begin
            cnt_d = LOAD[CNT_W-1:0];
        end else if (tick && (cnt_q != {CNT_W{1'b0}})) begin
            cnt_d = cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    // Counter register
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= {CNT_W{1'b0}};
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign busy = (cnt_q != {CNT_W{1'b0}});
    // One-cycle pulse on the tick that takes the count to zero
    assign expired = ~load & tick & (cnt_q == {{(CNT_W-1){1'b0}}, 1'b1});
endmodule
`default_nettype wire

// [tb/pwu_pin_model.sv]
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// External signal sources on the eight wake port pins
module pwu_pin_model (
    input wire logic clock,
    input wire logic [7:0] level,
    output var logic [7:0] port_in
);
    // Pins start low so the block never sees an unknown level
    initial port_in = 8'h00;

    // Levels move just after an edge, held until the bench asks for a change
    always @(posedge clock) begin
        port_in <= level;
    end
endmodule

`default_nettype wire

// [tb/pwu_top_assertions.sv]
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Port-level checks for the wake and port interrupt block
module pwu_top_assertions #(
    parameter PINS = 8,
    parameter ADDR_W = 8
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [PINS-1:0] port_in,
    input wire logic port_irq_req,
    input wire logic irq,
    input wire logic core_clk_en,
    input wire logic osc_en,
    input wire logic wake_pulse,
    input wire logic wake_to_isr
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    // Only the seven aligned words from 0x00 to 0x18 are decoded
    wire logic unmapped = (paddr > 8'h18) || (paddr[1:0] != 2'b00);

    // ============================================================
    // Clocking and wakeup
    chk_clk_order: assert property (!osc_en |-> !core_clk_en)
        else $error("core clock on while oscillator off");
    chk_start_hold: assert property ($rose(osc_en) |-> !core_clk_en [*6])
        else $error("core clock released before start delay");
    chk_start_bound: assert property ($rose(osc_en) |-> ##[1:60] core_clk_en)
        else $error("start delay never ends");
    chk_wake_pulse: assert property (wake_pulse |=> !wake_pulse)
        else $error("wake pulse longer than one cycle");
    chk_wake_run: assert property (wake_pulse |-> core_clk_en)
        else $error("wake pulse without running core");
    chk_isr_hold: assert property ($changed(wake_to_isr) |-> wake_pulse)
        else $error("handler flag moved outside a wake");

    // ============================================================
    // Interrupt request and register bus
    chk_req_rise: assert property ($rose(port_irq_req) |-> $past(psel && penable && pwrite)
        || ($past(port_in, 3) != $past(port_in, 4)) || ($past(port_in, 2) != $past(port_in, 3)))
        else $error("request rose without pin edge or write");
    chk_req_fall: assert property ($fell(port_irq_req) |-> $past(psel && penable && pwrite))
        else $error("request dropped without a software write");
    chk_err_map: assert property (psel && penable |-> pslverr == unmapped)
        else $error("error response does not match decode");
    chk_rd_upper: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    chk_zero_wait: assert property (psel && penable |-> pready)
        else $error("wait state inserted in access phase");

    // Main scenarios
    cover property ($rose(osc_en));
    cover property (wake_pulse && wake_to_isr);
    cover property (irq && psel && penable && !pwrite);
endmodule

bind pwu_top pwu_top_assertions #(.PINS(PINS), .ADDR_W(ADDR_W)) u_chk (
    .clock(clock), .rst_b(rst_b), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_in(port_in), .port_irq_req(port_irq_req), .irq(irq), .core_clk_en(core_clk_en),
    .osc_en(osc_en), .wake_pulse(wake_pulse), .wake_to_isr(wake_to_isr)
);

`default_nettype wire

// [tb/port_wakeup_interrupt_logic_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pwu_defines.vh"

// ============================================================
// Self-checking bench with an integer model of the wake registers
module port_wakeup_interrupt_logic_tb;
    localparam int STARTUP = 4; // Short start delay keeps the run brief
    localparam int TC_DIV = 2;
    localparam logic [7:0] EN = `PWU_OFF_WAKE_EN;
    localparam logic [7:0] EDG = `PWU_OFF_WAKE_EDGE;
    localparam logic [7:0] PND = `PWU_OFF_WAKE_PEND;
    localparam logic [7:0] CTL = `PWU_OFF_IRQ_CTRL;
    localparam logic [7:0] PWR = `PWU_OFF_POWER;
    localparam logic [7:0] STA = `PWU_OFF_EVT_STATUS;
    localparam logic [7:0] MSK = `PWU_OFF_EVT_MASK;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h00000000;
    logic [7:0] level = 8'h00; // Requested pin levels
    logic [31:0] prdata, rdata;
    logic pready, pslverr, port_irq_req, irq, core_clk_en, osc_en, wake_pulse, wake_to_isr, err;
    logic [7:0] port_in;
    int n_errors = 0;
    int checked = 0;
    int cycles = 0;
    int m_en, m_pnd, e, p0, p1, n, k, seed; // Model registers and scratch
    int exp_q[$]; // Expected pending words, oldest first

    always #12.5 clock = ~clock;

    pwu_pin_model pins (.clock(clock), .level(level), .port_in(port_in));
    pwu_top #(.TC_DIV(TC_DIV), .STARTUP(STARTUP)) dut (
        .clock(clock), .rst_b(rst_b), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .port_in(port_in), .port_irq_req(port_irq_req), .irq(irq), .core_clk_en(core_clk_en),
        .osc_en(osc_en), .wake_pulse(wake_pulse), .wake_to_isr(wake_to_isr)
    );

    // ============================================================
    // Shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // One transfer; the request stands until pready is seen high
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input int d);
        apb(a, 1'b1, d);
    endtask

    task automatic rd(input logic [7:0] a, input int exp);
        apb(a, 1'b0, $urandom);
        chk(rdata, exp);
    endtask

    task automatic cyc(input int c);
        repeat (c) @(posedge clock);
    endtask

    task automatic pin(input int v);
        @(posedge clock);
        level <= v[7:0];
    endtask

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Hang guard, well above the few hundred cycles the tests need
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            $display("unexpected at %0t: run timed out", $time);
            summarize;
        end
    end

    // ============================================================
    // Main sequence
    initial begin
        seed = $urandom(32'h1c4ad22f);
        cyc(10);
        rst_b <= 1'b1;
        // Reset values, then an unmapped word
        for (n = 0; n <= 24; n += 4) rd(n[7:0], 0);
        rd(8'h40, 0);
        chk(err, 1);
        $display("test 1 done");
        // Enable and edge registers take any byte, upper bits ignored
        for (n = 0; n < 4; n++) begin
            e = $urandom;
            p0 = $urandom;
            wr(EN, e);
            wr(EDG, p0);
            rd(EN, e & 255);
            rd(EDG, p0 & 255);
        end
        wr(EN, 0);
        $display("test 2 done");
        // Random edges of both polarities, pending cleared after pins settle
        for (n = 0; n < 6; n++) begin
            e = $urandom & 255;
            p0 = $urandom & 255;
            p1 = $urandom & 255;
            wr(EDG, e);
            pin(p0);
            cyc(6);
            wr(PND, 0);
            pin(p1);
            cyc(6);
            m_pnd = ((~p0 & p1 & ~e) | (p0 & ~p1 & e)) & 255;
            exp_q.push_back(m_pnd);
            rd(PND, exp_q.pop_front());
        end
        $display("test 3 done");
        // Pending bits stand until software rewrites them
        cyc(20);
        rd(PND, m_pnd);
        m_pnd = $urandom & 255;
        wr(PND, m_pnd);
        rd(PND, m_pnd);
        $display("test 4 done");
        // Request needs an enabled pending pin and both enable bits
        wr(PND, 8'h5a);
        m_pnd = 8'h5a;
        for (n = 0; n < 8; n++) begin
            m_en = n[2] ? 255 : 0;
            wr(EN, m_en);
            wr(CTL, n & 3);
            @(negedge clock);
            chk(port_irq_req, ((n & 3) == 3) && ((m_en & m_pnd) != 0));
        end
        $display("test 5 done");
        // Halt must be refused while an enabled pin is pending
        wr(PWR, 1);
        cyc(2);
        @(negedge clock);
        chk(core_clk_en, 1);
        rd(STA, 2);
        rd(STA, 0);
        $display("test 6 done");
        // Idle wake without handler, then halt wake with handler and start delay
        wr(MSK, 4);
        rd(MSK, 4);
        for (k = 0; k < 2; k++) begin
            wr(EN, 0);
            wr(EDG, 0);
            pin(0);
            cyc(6);
            wr(PND, 0);
            wr(EN, 1);
            wr(CTL, k ? 3 : 0);
            wr(PWR, k ? 1 : 2);
            cyc(1);
            @(negedge clock);
            chk(core_clk_en, 0);
            chk(osc_en, k ? 0 : 1);
            pin(1);
            n = 0;
            while (wake_pulse !== 1'b1 && n < 400) begin
                @(negedge clock);
                n++;
            end
            chk(wake_pulse, 1);
            chk(wake_to_isr, k);
            if (k == 1) chk(n >= STARTUP * TC_DIV, 1);
            cyc(2);
            @(negedge clock);
            chk(irq, k);
            rd(STA, k ? 5 : 1);
            @(negedge clock);
            chk(irq, 0);
        end
        $display("test 7 done");
        summarize;
    end
endmodule

`default_nettype wire
